// [src/smart_report_pkg.sv]
/*
 * Shared constants for the attribute report and automatic off-line
 * collection control block: register map, data structure layout,
 * fixed report values and subcommand codes.
 * Assumes a 32-bit AXI4-Lite register bus and one 200 MHz clock.
 */
package smart_report_pkg;
	// -------------------------------------------------------------
	// Register byte offsets
	// -------------------------------------------------------------
	localparam logic [11:0] CMD_OFS      = 12'h000; // Sector count, runs control
	localparam logic [11:0] STATUS_OFS   = 12'h004; // Enable, error, status bytes
	localparam logic [11:0] OFFSTATE_OFS = 12'h008; // Off-line state code
	localparam logic [11:0] SELFTEST_OFS = 12'h00c; // Self-test progress
	localparam logic [11:0] TIMES_OFS    = 12'h010; // Durations
	localparam logic [11:0] EXTWORD_OFS  = 12'h014; // Extended time word
	localparam logic [11:0] SLOTSEL_OFS  = 12'h018; // Attribute slot index
	localparam logic [11:0] SLOTCFG_OFS  = 12'h01c; // Id and flags of slot
	localparam logic [11:0] SLOTRAW_OFS  = 12'h020; // Raw count of slot
	localparam logic [11:0] RDSTART_OFS  = 12'h024; // Restart the block read
	localparam logic [11:0] RDDATA_OFS   = 12'h028; // Next four block bytes
	// -------------------------------------------------------------
	// Subcommand values in the sector count byte
	// -------------------------------------------------------------
	localparam logic [7:0] AUTO_OFF_VAL = 8'h00;
	localparam logic [7:0] AUTO_ON_VAL  = 8'hf8;
	// -------------------------------------------------------------
	// Data structure layout
	// -------------------------------------------------------------
	localparam logic [8:0]  SLOT_BASE    = 9'h002;
	localparam logic [8:0]  SLOT_END     = 9'h16a; // First byte past slot 30
	localparam logic [3:0]  SLOT_BYTES   = 4'hc;
	localparam logic [8:0]  OFFSTAT_POS  = 9'h16a;
	localparam logic [8:0]  SELFSTAT_POS = 9'h16b;
	localparam logic [8:0]  OFFSEC_POS   = 9'h16c;
	localparam logic [8:0]  OFFCAP_POS   = 9'h16f;
	localparam logic [8:0]  CAPWORD_POS  = 9'h170;
	localparam logic [8:0]  ERRCAP_POS   = 9'h172;
	localparam logic [8:0]  CHKPT_POS    = 9'h173;
	localparam logic [8:0]  SHORT_POS    = 9'h174;
	localparam logic [8:0]  EXTMIN_POS   = 9'h175;
	localparam logic [8:0]  EXTWORD_POS  = 9'h177;
	localparam logic [6:0]  LAST_WORD    = 7'h7f;  // Word holding byte 1ffh
	localparam logic [15:0] REVISION     = 16'h0010;
	localparam logic [7:0]  OFFCAP_VAL   = 8'h1b;
	localparam logic [15:0] CAPWORD_VAL  = 16'h0003;
	localparam logic [7:0]  ERRCAP_VAL   = 8'h01;
	localparam logic [5:0]  FLAG_MASK    = 6'h3f;  // Bits 6-15 read zero
	// -------------------------------------------------------------
	// Normalisation and self-test limits
	// -------------------------------------------------------------
	localparam logic [7:0] NORM_MAX  = 8'hfd;
	localparam logic [7:0] NORM_MIN  = 8'h01;
	localparam logic [3:0] TENTHS_MAX = 4'h9;
	// -------------------------------------------------------------
	// Reset values
	// -------------------------------------------------------------
	localparam logic       AUTO_RST     = 1'b0;
	localparam logic [6:0] OFFSTATE_RST = 7'h00;
	// AXI answers
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : smart_report_pkg

// [src/smart_report_ctl.sv]
/*
 * Attribute report builder and automatic off-line collection control,
 * reached over AXI4-Lite. Software plays the host: it writes the sector
 * count byte to run the control subcommand and drains the 512-byte
 * report four bytes per read. Assumes a single synchronous clock
 * domain and a master with at most one write and one read in flight.
 */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Sector count zero disables automatic collection
// - Value f8h enables and starts collection
// - Other non-zero keeps setting, flags error
// - Saves on power events even when disabled
// - Whole 512-byte block, low byte first
// - Bytes 0-1 carry revision 0010h
// - Thirty 12-byte slots from 02h to 169h
// - Slot: id, flags, value 01h-fdh, vendor
// - Zero id marks an unused slot
// - Flag bit 0 marks pre-failure attribute
// - Flag bit 1 online; bits 6-15 zero
// - Raw counts converted to normalized values
// - Byte 16ah bit 7 shows enable state
// - Byte 16ah bits 0-6 hold state code
// - Self-test remaining tenths, values 0-9
// - Self-test outcome code in bits 4-7
// - Off-line seconds word at 16ch
// - Fixed capability bytes at 16fh-172h
// - Short and extended durations, ffh escape
// - Byte 173h gives failure check point
// - Byte 1ffh makes structure sum zero
module smart_report_ctl #(
	parameter int SLOTS = 30 // Attribute slots in the report
) (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        saveEvent,   // Power-on/off or recovery step
	output logic             autoCollect, // Collection engine may run
	output logic             nvSave       // Pulse: store attributes
);
	// ------------------------------------------------------------
	// Elaboration check
	// ------------------------------------------------------------
	if (SLOTS < 1 || SLOTS > 30)
	begin : g_bad_slots
		$error("SLOTS must lie between 1 and 30");
	end

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic        awHeld_q, awHeld_d;   // Write address captured
	logic [11:0] awAddr_q, awAddr_d;
	logic        wHeld_q, wHeld_d;     // Write data captured
	logic [31:0] wData_q, wData_d;
	logic [3:0]  wStrb_q, wStrb_d;
	logic        bValid_q, bValid_d;
	logic [1:0]  bResp_q, bResp_d;
	logic        rValid_q, rValid_d;
	logic [31:0] rData_q, rData_d;
	logic [1:0]  rResp_q, rResp_d;
	logic        autoEn_q, autoEn_d;   // Automatic collection on
	logic        cmdErr_q, cmdErr_d;   // Last control value refused
	logic [6:0]  offState_q, offState_d;
	logic [3:0]  tenths_q, tenths_d;
	logic [3:0]  outcome_q, outcome_d;
	logic [7:0]  chkPt_q, chkPt_d;
	logic [15:0] offSec_q, offSec_d;
	logic [7:0]  shortMin_q, shortMin_d;
	logic [7:0]  extMin_q, extMin_d;
	logic [15:0] extWord_q, extWord_d;
	logic [4:0]  slotSel_q, slotSel_d;
	logic [6:0]  ptr_q, ptr_d;         // Next word of the block
	logic [7:0]  sum_q, sum_d;         // Sum of bytes already sent
	logic        save_q, save_d;
	logic [7:0]  id_q   [SLOTS];       // Slot storage, flip-flops
	logic [5:0]  flag_q [SLOTS];
	logic [7:0]  norm_q [SLOTS];
	logic [31:0] raw_q  [SLOTS];

	// Write strobes decoded once both halves are held
	logic doWr;
	logic cmdGo;
	logic cfgWr;
	logic rawWr;
	logic arGo;
	logic dataRd;
	assign doWr   = ce && awHeld_q && wHeld_q && !bValid_q;
	assign cmdGo  = doWr && awAddr_q == smart_report_pkg::CMD_OFS && wStrb_q[0];
	assign cfgWr  = doWr && awAddr_q == smart_report_pkg::SLOTCFG_OFS;
	assign rawWr  = doWr && awAddr_q == smart_report_pkg::SLOTRAW_OFS;
	assign arGo   = ce && s_axi_arvalid && !rValid_q;
	assign dataRd = arGo && s_axi_araddr == smart_report_pkg::RDDATA_OFS;

	// ------------------------------------------------------------
	// Report byte generator
	// ------------------------------------------------------------
	// Raw count to value in 01h..fdh; larger counts mean worse health
	function automatic logic [7:0] normalize(input logic [31:0] raw);
		normalize = (raw >= 32'h0000_00fc) ? smart_report_pkg::NORM_MIN
		          : smart_report_pkg::NORM_MAX - raw[7:0];
	endfunction : normalize

	// One byte of the 512-byte structure, multi-byte fields LSB first
	function automatic logic [7:0] byteAt(input logic [8:0] a);
		logic [8:0] rel;
		logic [4:0] s;
		logic [3:0] o;
		rel = a - smart_report_pkg::SLOT_BASE;
		s = 5'(rel / 9'(smart_report_pkg::SLOT_BYTES));
		o = 4'(rel % 9'(smart_report_pkg::SLOT_BYTES));
		byteAt = 8'h00; // Reserved and vendor areas read zero
		if (a < smart_report_pkg::SLOT_BASE)
			byteAt = a[0] ? smart_report_pkg::REVISION[15:8]
			              : smart_report_pkg::REVISION[7:0];
		else if (a < smart_report_pkg::SLOT_END)
		begin
			if (32'(s) < SLOTS && id_q[s] != 8'h00)
			begin
				// Slot layout: id, flags, value, vendor bytes
				unique case (o)
					4'h0: byteAt = id_q[s];
					4'h1: byteAt = {2'b00, flag_q[s]};
					4'h2: byteAt = 8'h00;
					4'h3: byteAt = norm_q[s];
					4'h4: byteAt = raw_q[s][7:0];
					4'h5: byteAt = raw_q[s][15:8];
					4'h6: byteAt = raw_q[s][23:16];
					4'h7: byteAt = raw_q[s][31:24];
					default: byteAt = 8'h00;
				endcase
			end
		end
		else
		begin
			unique case (a)
				smart_report_pkg::OFFSTAT_POS:
					byteAt = {autoEn_q, offState_q};
				smart_report_pkg::SELFSTAT_POS:
					byteAt = {outcome_q, tenths_q};
				smart_report_pkg::OFFSEC_POS:      byteAt = offSec_q[7:0];
				smart_report_pkg::OFFSEC_POS + 9'h1: byteAt = offSec_q[15:8];
				smart_report_pkg::OFFCAP_POS:      byteAt = smart_report_pkg::OFFCAP_VAL;
				smart_report_pkg::CAPWORD_POS:     byteAt = smart_report_pkg::CAPWORD_VAL[7:0];
				smart_report_pkg::CAPWORD_POS + 9'h1:
					byteAt = smart_report_pkg::CAPWORD_VAL[15:8];
				smart_report_pkg::ERRCAP_POS:      byteAt = smart_report_pkg::ERRCAP_VAL;
				smart_report_pkg::CHKPT_POS:       byteAt = chkPt_q;
				smart_report_pkg::SHORT_POS:       byteAt = shortMin_q;
				smart_report_pkg::EXTMIN_POS:      byteAt = extMin_q;
				smart_report_pkg::EXTWORD_POS:     byteAt = extWord_q[7:0];
				smart_report_pkg::EXTWORD_POS + 9'h1: byteAt = extWord_q[15:8];
				default: byteAt = 8'h00;
			endcase
		end
	endfunction : byteAt

	// Four bytes of the current word; the last byte of word 127 is
	// replaced by the checksum. Slot edits during a read still leave the sent bytes summing to zero.
	logic [7:0] wb [4];
	logic [7:0] part;
	always_comb
	begin
		for (int k = 0; k < 4; k++)
			wb[k] = byteAt({ptr_q, 2'(k)});
		part = sum_q + wb[0] + wb[1] + wb[2];
		if (ptr_q == smart_report_pkg::LAST_WORD)
			wb[3] = 8'h00 - part;
	end

	// ------------------------------------------------------------
	// AXI write channel: address and data taken in either order
	// ------------------------------------------------------------
	logic wrMapped;
	always_comb
	begin
		awHeld_d = awHeld_q;
		awAddr_d = awAddr_q;
		wHeld_d  = wHeld_q;
		wData_d  = wData_q;
		wStrb_d  = wStrb_q;
		bValid_d = bValid_q;
		bResp_d  = bResp_q;
		wrMapped = awAddr_q <= smart_report_pkg::RDSTART_OFS && awAddr_q[1:0] == 2'b00;
		if (s_axi_awvalid && s_axi_awready)
		begin
			awHeld_d = 1'b1;
			awAddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			wHeld_d = 1'b1;
			wData_d = s_axi_wdata;
			wStrb_d = s_axi_wstrb;
		end
		if (doWr)
		begin
			// Status and data words are read-only: answer an error
			awHeld_d = 1'b0;
			wHeld_d  = 1'b0;
			bValid_d = 1'b1;
			bResp_d  = (wrMapped && awAddr_q != smart_report_pkg::STATUS_OFS)
			         ? smart_report_pkg::RESP_OKAY : smart_report_pkg::RESP_SLVERR;
		end
		if (bValid_q && s_axi_bready)
			bValid_d = 1'b0;
	end

	// ------------------------------------------------------------
	// Control and status fields written by software
	// ------------------------------------------------------------
	always_comb
	begin
		autoEn_d   = autoEn_q;
		cmdErr_d   = cmdErr_q;
		offState_d = offState_q;
		tenths_d   = tenths_q;
		outcome_d  = outcome_q;
		chkPt_d    = chkPt_q;
		offSec_d   = offSec_q;
		shortMin_d = shortMin_q;
		extMin_d   = extMin_q;
		extWord_d  = extWord_q;
		slotSel_d  = slotSel_q;
		save_d     = saveEvent; // Saved regardless of enable
		if (cmdGo)
		begin
			if (wData_q[7:0] == smart_report_pkg::AUTO_OFF_VAL)
			begin
				autoEn_d = 1'b0;
				cmdErr_d = 1'b0;
			end
			else if (wData_q[7:0] == smart_report_pkg::AUTO_ON_VAL)
			begin
				autoEn_d = 1'b1;
				cmdErr_d = 1'b0;
			end
			else
				cmdErr_d = 1'b1; // Setting kept
		end
		if (doWr)
		begin
			unique case (awAddr_q)
				smart_report_pkg::OFFSTATE_OFS: offState_d = wData_q[6:0];
				smart_report_pkg::SELFTEST_OFS:
				begin
					// Tenths above nine are clamped
					tenths_d  = (wData_q[3:0] > smart_report_pkg::TENTHS_MAX)
					          ? smart_report_pkg::TENTHS_MAX : wData_q[3:0];
					outcome_d = wData_q[7:4];
					chkPt_d   = wData_q[15:8];
				end
				smart_report_pkg::TIMES_OFS:
				begin
					offSec_d   = wData_q[15:0];
					shortMin_d = wData_q[23:16];
					extMin_d   = wData_q[31:24];
				end
				smart_report_pkg::EXTWORD_OFS: extWord_d = wData_q[15:0];
				smart_report_pkg::SLOTSEL_OFS:
					if (32'(wData_q[4:0]) < SLOTS)
						slotSel_d = wData_q[4:0];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Read channel and block pointer
	// ------------------------------------------------------------
	always_comb
	begin
		rValid_d = rValid_q;
		rData_d  = rData_q;
		rResp_d  = rResp_q;
		ptr_d    = ptr_q;
		sum_d    = sum_q;
		if (doWr && awAddr_q == smart_report_pkg::RDSTART_OFS)
		begin
			ptr_d = 7'h00;
			sum_d = 8'h00;
		end
		if (arGo)
		begin
			rValid_d = 1'b1;
			rResp_d  = smart_report_pkg::RESP_OKAY;
			unique case (s_axi_araddr)
				smart_report_pkg::STATUS_OFS:
					rData_d = {8'h00, outcome_q, tenths_q, autoEn_q, offState_q,
					           6'h00, cmdErr_q, autoEn_q};
				smart_report_pkg::SLOTSEL_OFS:  rData_d = {27'h0, slotSel_q};
				smart_report_pkg::RDSTART_OFS:  rData_d = {25'h0, ptr_q};
				smart_report_pkg::RDDATA_OFS:
				begin
					rData_d = {wb[3], wb[2], wb[1], wb[0]};
					ptr_d   = ptr_q + 7'h01; // Wraps after the last word
					sum_d   = (ptr_q == smart_report_pkg::LAST_WORD) ? 8'h00 : part + wb[3];
				end
				default:
				begin
					rData_d = 32'h0;
					rResp_d = smart_report_pkg::RESP_SLVERR;
				end
			endcase
		end
		else if (rValid_q && s_axi_rready)
			rValid_d = 1'b0;
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			awHeld_q <= 1'b0; awAddr_q <= 12'h0; wHeld_q <= 1'b0;
			wData_q <= 32'h0; wStrb_q <= 4'h0; bValid_q <= 1'b0;
			bResp_q <= 2'b00; rValid_q <= 1'b0; rData_q <= 32'h0;
			rResp_q <= 2'b00; autoEn_q <= smart_report_pkg::AUTO_RST;
			cmdErr_q <= 1'b0; offState_q <= smart_report_pkg::OFFSTATE_RST;
			tenths_q <= 4'h0; outcome_q <= 4'h0; chkPt_q <= 8'h00;
			offSec_q <= 16'h0; shortMin_q <= 8'h00; extMin_q <= 8'h00;
			extWord_q <= 16'h0; slotSel_q <= 5'h00; ptr_q <= 7'h00;
			sum_q <= 8'h00; save_q <= 1'b0;
		end
		else if (ce)
		begin
			awHeld_q <= awHeld_d; awAddr_q <= awAddr_d; wHeld_q <= wHeld_d;
			wData_q <= wData_d; wStrb_q <= wStrb_d; bValid_q <= bValid_d;
			bResp_q <= bResp_d; rValid_q <= rValid_d; rData_q <= rData_d;
			rResp_q <= rResp_d; autoEn_q <= autoEn_d; cmdErr_q <= cmdErr_d;
			offState_q <= offState_d; tenths_q <= tenths_d;
			outcome_q <= outcome_d; chkPt_q <= chkPt_d; offSec_q <= offSec_d;
			shortMin_q <= shortMin_d; extMin_q <= extMin_d;
			extWord_q <= extWord_d; slotSel_q <= slotSel_d; ptr_q <= ptr_d;
			sum_q <= sum_d; save_q <= save_d;
		end
	end

	// Per-slot storage: one generate loop, written through the index
	for (genvar g = 0; g < SLOTS; g++)
	begin : g_slot
		logic [7:0]  idD;
		logic [5:0]  flagD;
		logic [7:0]  normD;
		logic [31:0] rawD;
		logic        hit;
		always_comb
		begin
			hit   = 32'(slotSel_q) == g;
			idD   = id_q[g];
			flagD = flag_q[g];
			normD = norm_q[g];
			rawD  = raw_q[g];
			if (cfgWr && hit)
			begin
				idD   = wData_q[7:0];
				flagD = wData_q[13:8] & smart_report_pkg::FLAG_MASK;
			end
			if (rawWr && hit)
			begin
				rawD  = wData_q;
				normD = normalize(wData_q);
			end
		end
		always_ff @(posedge sys_clk)
		begin
			if (rst)
			begin
				id_q[g]   <= 8'h00; // Empty slot after reset
				flag_q[g] <= 6'h00;
				norm_q[g] <= smart_report_pkg::NORM_MAX;
				raw_q[g]  <= 32'h0;
			end
			else if (ce)
			begin
				id_q[g]   <= idD;
				flag_q[g] <= flagD;
				norm_q[g] <= normD;
				raw_q[g]  <= rawD;
			end
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign s_axi_awready = !awHeld_q;
	assign s_axi_wready  = !wHeld_q;
	assign s_axi_bvalid  = bValid_q;
	assign s_axi_bresp   = bResp_q;
	assign s_axi_arready = !rValid_q;
	assign s_axi_rvalid  = rValid_q;
	assign s_axi_rdata   = rData_q;
	assign s_axi_rresp   = rResp_q;
	assign autoCollect   = autoEn_q; // Starts or resumes collection
	assign nvSave        = save_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// Helper: running sum of every byte returned in the block
	logic [7:0] chkAcc_q;
	always_ff @(posedge sys_clk)
		if (rst)
			chkAcc_q <= 8'h00;
		else if (dataRd)
			chkAcc_q <= (ptr_q == smart_report_pkg::LAST_WORD) ? 8'h00
			          : chkAcc_q + wb[0] + wb[1] + wb[2] + wb[3];
		else if (doWr && awAddr_q == smart_report_pkg::RDSTART_OFS)
			chkAcc_q <= 8'h00; // Restart clears it, as it clears the pointer

	sequence enCmd;
		cmdGo && wData_q[7:0] == smart_report_pkg::AUTO_ON_VAL;
	endsequence
	sequence statusRd;
		arGo && s_axi_araddr == smart_report_pkg::STATUS_OFS;
	endsequence

	chk_zero_disables: assert property (cmdGo && wData_q[7:0] == 8'h00 |=> !autoCollect)
		else $error("zero value did not disable collection");
	chk_f8_enables: assert property (enCmd ##1 (!cmdGo)[*2] |-> autoCollect)
		else $error("f8h value did not enable collection");
	chk_other_keeps: assert property (cmdGo && wData_q[7:0] != 8'h00 && wData_q[7:0] != 8'hf8
		|=> $stable(autoEn_q) && cmdErr_q)
		else $error("other value changed the setting");
	chk_save_pulse: assert property (ce && saveEvent |=> nvSave)
		else $error("power event did not save");
	chk_rev_word: assert property (dataRd && ptr_q == 7'h00
		|=> s_axi_rdata[15:0] == 16'h0010)
		else $error("revision word wrong");
	chk_norm_range: assert property (rawWr |=> norm_q[slotSel_q] >= 8'h01
		&& norm_q[slotSel_q] <= 8'hfd)
		else $error("normalized value out of range");
	chk_status_bit7: assert property (statusRd |=> s_axi_rdata[15] == $past(autoCollect))
		else $error("status bit 7 does not follow enable");
	chk_tenths_max: assert property (tenths_q <= 4'h9)
		else $error("remaining tenths above nine");
	chk_fixed_caps: assert property (byteAt(9'h16f) == 8'h1b && byteAt(9'h170) == 8'h03
		&& byteAt(9'h172) == 8'h01)
		else $error("capability bytes wrong");
	chk_block_sum: assert property (dataRd && ptr_q == 7'h7f
		|=> 8'($past(chkAcc_q) + s_axi_rdata[7:0] + s_axi_rdata[15:8] + s_axi_rdata[23:16]
		+ s_axi_rdata[31:24]) == 8'h00)
		else $error("structure does not sum to zero");
endmodule : smart_report_ctl

`default_nettype wire

// [dv/host_axi_model.sv]
/*
 * Host model: AXI4-Lite master tasks that play the host's register access.
 * Assumes one clock; an answer that never comes returns response 2'b11.
 */
`timescale 1ns/1ps
`default_nettype none
module host_axi_model (
	output logic             s_axi_awvalid,
	output logic [11:0]      s_axi_awaddr,
	input  wire logic        sys_clk,
	input  wire logic        s_axi_awready,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	output logic [11:0]      s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready
);
	// ------------------------------
	// Bus idle at time zero
	// ------------------------------
	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
	end
	// Released addresses and write data are inverted so a stale value is never trusted; wstrb is left as it is
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		r = 2'b11;
		@(posedge sys_clk);
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (int n = 0; n < 64; n++)
		begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
			if (s_axi_wvalid && s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
			if (s_axi_bvalid)
			begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask : wr
	// Read: rready held from the start until rvalid is seen
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		r = 2'b11;
		d = 32'h0;
		@(posedge sys_clk);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
		for (int n = 0; n < 64; n++)
		begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
			if (s_axi_rvalid)
			begin
				{r, d} = {s_axi_rresp, s_axi_rdata};
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask : rd
endmodule : host_axi_model
`default_nettype wire

// [dv/tb.sv]
/*
 * Bench: runs the off-line control subcommand, fills the report fields
 * and reads the whole block back. Assumes the host model above.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
	wire logic [11:0] s_axi_awaddr, s_axi_araddr;
	wire logic [31:0] s_axi_wdata, s_axi_rdata;
	wire logic [3:0]  s_axi_wstrb;
	wire logic [1:0]  s_axi_bresp, s_axi_rresp;
	wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	wire logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	wire logic        autoCollect, nvSave;
	logic             sys_clk, rst, saveEvent, ce;
	logic [7:0]       expB [512]; // Expected report bytes
	int               errorCnt, testsRun;
	smart_report_ctl #(.SLOTS(30)) u_smart_report_ctl (.sys_clk, .rst, .ce,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .saveEvent, .autoCollect, .nvSave);
	host_axi_model u_host_model (.sys_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	// ------------------------------
	// Clock, checks and access tasks
	// ------------------------------
	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	task automatic endOfTest();
		$display("compares %0d mismatches %0d", testsRun, errorCnt);
		if (errorCnt == 0 && testsRun > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : endOfTest
	task automatic cmpD(input logic [31:0] g, input logic [31:0] e);
		testsRun++;
		if (g !== e)
		begin
			errorCnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmpD
	task automatic cmpR(input logic [1:0] g, input logic [1:0] e);
		cmpD({30'h0, g}, {30'h0, e});
	endtask : cmpR
	// A response of 11 means the model gave up waiting
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] e);
		logic [1:0] r;
		u_host_model.wr(a, d, s, r);
		cmpR(r, e);
		if (r === 2'b11) endOfTest();
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] e);
		logic [1:0] r;
		u_host_model.rd(a, d, r);
		cmpR(r, e);
		if (r === 2'b11) endOfTest();
	endtask : rd
	// Bytes listed in address order from position at
	task automatic put(input int at, input logic [119:0] v, input int n);
		for (int i = 0; i < n; i++) expB[at + i] = v[8 * (n - 1 - i) +: 8];
	endtask : put
	// ------------------------------
	// Test sequence
	// ------------------------------
	initial
	begin
		logic [31:0] d;
		logic [7:0]  s;
		logic [13:0] ctl [6]; // Sector count, strobes, enable, refused
		logic [43:0] fld [10]; // Address and data of field writes
		errorCnt = 0;
		testsRun = 0;
		rst = 1'b1;
		ce = 1'b1;
		saveEvent = 1'b0;
		ctl = '{14'h3e06, 14'h0147, 14'h0004, 14'h3e38, 14'h1fc5, 14'h3e06};
		fld = '{{smart_report_pkg::OFFSTATE_OFS, 32'h2}, {smart_report_pkg::SELFTEST_OFS, 32'h33fc},
			{smart_report_pkg::TIMES_OFS, 32'hff021234}, {smart_report_pkg::EXTWORD_OFS, 32'h155},
			{smart_report_pkg::SLOTSEL_OFS, 32'h0}, {smart_report_pkg::SLOTCFG_OFS, 32'hff05},
			{smart_report_pkg::SLOTRAW_OFS, 32'h10}, {smart_report_pkg::SLOTSEL_OFS, 32'h1d},
			{smart_report_pkg::SLOTCFG_OFS, 32'h1c2}, {smart_report_pkg::SLOTRAW_OFS, 32'h100}};
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		cmpD({30'h0, autoCollect, nvSave}, 32'h0);
		// Store request while collection is off
		@(posedge sys_clk);
		saveEvent <= 1'b1;
		@(posedge sys_clk);
		saveEvent <= 1'b0;
		#1 cmpD({31'h0, nvSave}, 32'h1);
		@(posedge sys_clk);
		#1 cmpD({31'h0, nvSave}, 32'h0);
		// Clock enable low freezes state: the store request is not taken
		@(posedge sys_clk);
		ce <= 1'b0;
		saveEvent <= 1'b1;
		@(posedge sys_clk);
		ce <= 1'b1;
		saveEvent <= 1'b0;
		#1 cmpD({31'h0, nvSave}, 32'h0);
		$display("test save done");
		// Control values, including a write that misses the count byte
		for (int k = 0; k < 6; k++)
		begin
			wr(smart_report_pkg::CMD_OFS, {24'h0, ctl[k][13:6]}, ctl[k][5:2], 2'b00);
			rd(smart_report_pkg::STATUS_OFS, d, 2'b00);
			cmpD({22'h0, d[15:8], d[1:0]}, {22'h0, ctl[k][1], 7'h0, ctl[k][0], ctl[k][1]});
			cmpD({31'h0, autoCollect}, {31'h0, ctl[k][1]});
		end
		$display("test control done");
		wr(smart_report_pkg::STATUS_OFS, 32'h1, 4'hf, 2'b10);
		rd(12'h100, d, 2'b10);
		$display("test errors done");
		for (int k = 0; k < 10; k++) wr(fld[k][43:32], fld[k][31:0], 4'hf, 2'b00);
		expB = '{default: 8'h00};
		put(0, 120'h1000, 2);
		put(2, 120'h05_3f00_ed_10000000, 8);
		put(350, 120'hc2_0100_01_00010000, 8);
		put(362, 120'h82_f9_3412_00_1b_0300_01_33_02_ff_00_5501, 15);
		s = 8'h00;
		for (int i = 0; i < 511; i++) s += expB[i];
		expB[511] = 8'h00 - s;
		s = 8'h00;
		wr(smart_report_pkg::RDSTART_OFS, 32'h0, 4'hf, 2'b00);
		for (int k = 0; k < 128; k++)
		begin
			rd(smart_report_pkg::RDDATA_OFS, d, 2'b00);
			cmpD(d, {expB[4*k+3], expB[4*k+2], expB[4*k+1], expB[4*k]});
			s += d[7:0] + d[15:8] + d[23:16] + d[31:24];
		end
		cmpD({24'h0, s}, 32'h0);
		// Slot index past the last slot is ignored; pointer wrapped
		wr(smart_report_pkg::SLOTSEL_OFS, 32'h1e, 4'hf, 2'b00);
		rd(smart_report_pkg::SLOTSEL_OFS, d, 2'b00);
		cmpD(d, 32'h1d);
		rd(smart_report_pkg::RDSTART_OFS, d, 2'b00);
		cmpD(d, 32'h0);
		$display("test report done");
		endOfTest();
	end
endmodule : tb
`default_nettype wire
